/* design/trace_trig_pkg.sv */
// constants, offsets, field positions and mode codes of the bus-trace trigger block
// assumes a 32-bit AXI4-Lite register bus and an 8-bit CPU data bus
package trace_trig_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_TRACE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TRIGGER_CONFIG = 8'h04;
    localparam logic [7:0] OFS_RUN_STATUS = 8'h08;
    localparam logic [7:0] OFS_COMP_A = 8'h0C;
    localparam logic [7:0] OFS_COMP_B = 8'h10;
    localparam logic [7:0] OFS_FIFO_HIGH_BYTE = 8'h14;
    localparam logic [7:0] OFS_FIFO_LOW_BYTE = 8'h18;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_MODULE_ENABLE = 7;
    localparam int CTL_CAPTURE_ACTIVE = 6;
    localparam int CTL_BREAK_TAG = 5;
    localparam int CTL_BREAK_ENABLE = 4;
    localparam int CFG_TRIGGER_TYPE = 7;
    localparam int CFG_BEGIN_SELECT = 6;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hCF;
    localparam int STS_COMP_A_FLAG = 7;
    localparam int STS_COMP_B_FLAG = 6;
    localparam int STS_CAPTURE_ACTIVE = 5;

    // ************************************************************
    // reset values and sizes
    // ************************************************************
    localparam logic [7:0] RST_TRACE_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRIGGER_CONFIG = 8'h00;
    localparam logic [15:0] RST_COMP = 16'h0000;
    localparam int FIFO_WORDS = 8;
    localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // trigger modes
    // ************************************************************
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_DATA = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_DATA = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;

    function automatic logic addrMapped(input logic [7:0] a);
        addrMapped = (a == OFS_TRACE_CONTROL) || (a == OFS_TRIGGER_CONFIG) ||
            (a == OFS_RUN_STATUS) || (a == OFS_COMP_A) || (a == OFS_COMP_B) ||
            (a == OFS_FIFO_HIGH_BYTE) || (a == OFS_FIFO_LOW_BYTE);
    endfunction : addrMapped

    function automatic logic eventOnlyMode(input logic [3:0] m);
        eventOnlyMode = (m == MODE_EVENT_B) || (m == MODE_A_THEN_EVENT_B);
    endfunction : eventOnlyMode

endpackage : trace_trig_pkg

/* design/axil_reg_slave.sv */
// AXI4-Lite slave front end: turns bus transfers into one-cycle register strobes
// assumes the register file answers reads combinationally in the strobe cycle
`timescale 1ns/100ps
module axil_reg_slave (
    input wire logic clk, // bus clock
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic wrEn, // one-cycle register write strobe
    output logic [7:0] wrAddr, // register write address
    output logic [31:0] wrData, // register write data
    output logic [3:0] wrStrb, // register write byte enables
    output logic rdEn, // one-cycle register read strobe
    output logic [7:0] rdAddr, // register read address
    input wire logic [31:0] rdValue // register read value during rdEn
);
    import trace_trig_pkg::*;

    typedef struct packed {
        logic awGot;
        logic wGot;
        logic awReady;
        logic wReady;
        logic [7:0] wAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic wrPulse;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rdPulse;
        logic [7:0] rAddr;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } slave_t;

    slave_t st_r;
    slave_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wrPulse = 1'b0;
        st_nxt.rdPulse = 1'b0;
        if (awvalid && st_r.awReady) begin
            st_nxt.awGot = 1'b1;
            st_nxt.wAddr = awaddr;
        end
        if (wvalid && st_r.wReady) begin
            st_nxt.wGot = 1'b1;
            st_nxt.wData = wdata;
            st_nxt.wStrb = wstrb;
        end
        if (st_r.awGot && st_r.wGot && !st_r.bValid) begin
            // unmapped writes are dropped but still answered
            st_nxt.wrPulse = addrMapped(st_r.wAddr);
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = addrMapped(st_r.wAddr) ? RESP_OKAY : RESP_SLVERR;
            st_nxt.awGot = 1'b0;
            st_nxt.wGot = 1'b0;
        end else if (st_r.bValid && bready) begin
            st_nxt.bValid = 1'b0;
        end
        st_nxt.awReady = !st_nxt.awGot && !st_nxt.bValid;
        st_nxt.wReady = !st_nxt.wGot && !st_nxt.bValid;
        if (arvalid && st_r.arReady) begin
            st_nxt.arReady = 1'b0;
            st_nxt.rAddr = araddr;
            st_nxt.rdPulse = addrMapped(araddr);
            st_nxt.rResp = addrMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_r.rdPulse || (!st_r.arReady && !st_r.rValid)) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rData = st_r.rdPulse ? rdValue : 32'h00000000;
        end else if (st_r.rValid && rready) begin
            st_nxt.rValid = 1'b0;
            st_nxt.arReady = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.awReady <= 1'b1;
            st_r.wReady <= 1'b1;
            st_r.arReady <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.awReady;
    assign wready = st_r.wReady;
    assign bvalid = st_r.bValid;
    assign bresp = st_r.bResp;
    assign arready = st_r.arReady;
    assign rvalid = st_r.rValid;
    assign rdata = st_r.rData;
    assign rresp = st_r.rResp;
    assign wrEn = st_r.wrPulse;
    assign wrAddr = st_r.wAddr;
    assign wrData = st_r.wData;
    assign wrStrb = st_r.wStrb;
    assign rdEn = st_r.rdPulse;
    assign rdAddr = st_r.rAddr;

endmodule : axil_reg_slave

/* design/bus_trace_trigger.sv */
// bus-trace trigger selection, run status and eight-word capture store
// assumes CPU bus strobes are synchronous to clk and valid for one cycle each
`timescale 1ns/100ps
module bus_trace_trigger #(
    parameter int DEPTH = trace_trig_pkg::FIFO_WORDS // capture store words
) (
    input wire logic clk, // CPU bus clock, 40 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    output logic awready, // AXI write address ready
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI write strobes
    input wire logic wvalid, // AXI write data valid
    output logic wready, // AXI write data ready
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI write response valid
    input wire logic bready, // AXI write response ready
    input wire logic [7:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    output logic arready, // AXI read address ready
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI read valid
    input wire logic rready, // AXI read ready
    input wire logic busValid, // CPU bus cycle strobe
    input wire logic [15:0] busAddr, // CPU bus address
    input wire logic [7:0] busData, // CPU bus data
    input wire logic opcodeFetch, // current cycle is an opcode fetch
    input wire logic opcodeExec, // last fetched opcode executes now
    input wire logic secure, // device is in secure state
    output logic breakReq, // one-cycle CPU break request
    output logic breakTag // break type: 1 tag, 0 force
);
    import trace_trig_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_TRIG, STORE, CIRCULAR} run_t;

    typedef struct packed {
        run_t run;
        logic [7:0] control;
        logic [7:0] trigCfg;
        logic [15:0] compA;
        logic [15:0] compB;
        logic flagA;
        logic flagB;
        logic seenA;
        logic pendA;
        logic pendB;
        logic [3:0] count;
        logic [2:0] wrPtr;
        logic [2:0] rdPtr;
        logic brk;
        logic [DEPTH-1:0][15:0] fifo;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic rdEn;
    logic [7:0] rdAddr;
    logic [31:0] rdValue;

    axil_reg_slave u_slave (
        .clk(clk),
        .rst_b(rst_b),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .rdEn(rdEn),
        .rdAddr(rdAddr),
        .rdValue(rdValue)
    );

    // ************************************************************
    // comparators and trigger mode decode
    // ************************************************************
    logic [3:0] mode;
    logic eventMode;
    logic beginTrace;
    logic rawA;
    logic rawB;
    logic hitA;
    logic hitB;
    logic dataEq;
    logic trig;
    logic armed;
    logic [7:0] statusByte;

    assign mode = st_r.trigCfg[3:0];
    assign eventMode = eventOnlyMode(mode);
    assign beginTrace = st_r.trigCfg[CFG_BEGIN_SELECT] || eventMode;
    assign armed = st_r.run != IDLE;
    assign rawA = busValid && (busAddr == st_r.compA);
    assign rawB = busValid && (busAddr == st_r.compB);
    assign dataEq = busData == st_r.compB[7:0];
    // tag type waits for the matched opcode to execute; force fires on the access
    assign hitA = st_r.trigCfg[CFG_TRIGGER_TYPE] ? (opcodeExec && st_r.pendA) : rawA;
    assign hitB = st_r.trigCfg[CFG_TRIGGER_TYPE] ? (opcodeExec && st_r.pendB) : rawB;

    always_comb begin
        case (mode)
            MODE_A_ONLY: trig = hitA;
            MODE_A_OR_B: trig = hitA || hitB;
            MODE_A_THEN_B, MODE_A_THEN_EVENT_B: trig = st_r.seenA && hitB;
            MODE_EVENT_B: trig = hitB;
            MODE_A_AND_DATA: trig = hitA && dataEq;
            MODE_A_AND_NOT_DATA: trig = hitA && !dataEq;
            MODE_INSIDE: trig = busValid && busAddr >= st_r.compA &&
                busAddr <= st_r.compB;
            MODE_OUTSIDE: trig = busValid && (busAddr < st_r.compA ||
                busAddr > st_r.compB);
            default: trig = 1'b0;
        endcase
    end

    // ************************************************************
    // register read mux
    // ************************************************************
    assign statusByte = {st_r.flagA, st_r.flagB,
        st_r.control[CTL_MODULE_ENABLE] && armed, 1'b0, st_r.count};

    always_comb begin
        case (rdAddr)
            OFS_TRACE_CONTROL: rdValue = {24'h000000, st_r.control};
            OFS_TRIGGER_CONFIG: rdValue = {24'h000000, st_r.trigCfg};
            OFS_RUN_STATUS: rdValue = {24'h000000, statusByte};
            OFS_COMP_A: rdValue = {16'h0000, st_r.compA};
            OFS_COMP_B: rdValue = {16'h0000, st_r.compB};
            OFS_FIFO_HIGH_BYTE: rdValue = {24'h000000,
                eventMode ? 8'h00 : st_r.fifo[st_r.rdPtr][15:8]};
            OFS_FIFO_LOW_BYTE: rdValue = {24'h000000, st_r.fifo[st_r.rdPtr][7:0]};
            default: rdValue = 32'h00000000;
        endcase
    end

    // ************************************************************
    // run control and capture
    // ************************************************************
    logic storeNow;
    logic [15:0] storeWord;

    // event-only modes keep just the data byte of each B event
    assign storeWord = eventMode ? {8'h00, busData} : busAddr;

    always_comb begin
        st_nxt = st_r;
        st_nxt.brk = 1'b0;
        storeNow = 1'b0;
        if (busValid && opcodeFetch) begin
            st_nxt.pendA = rawA;
            st_nxt.pendB = rawB;
        end
        if (armed) begin
            if (hitA) begin
                st_nxt.flagA = 1'b1;
                st_nxt.seenA = 1'b1;
            end
            if (hitB) begin
                st_nxt.flagB = 1'b1;
            end
        end
        case (st_r.run)
            IDLE: begin
                // a low-byte read while idle steps the read pointer along the capture store
                if (rdEn && rdAddr == OFS_FIFO_LOW_BYTE) begin
                    st_nxt.rdPtr = st_r.rdPtr + 3'h1;
                end
            end
            WAIT_TRIG: begin
                if (trig) begin
                    st_nxt.run = STORE;
                    storeNow = eventMode ? hitB : busValid && opcodeFetch;
                end
            end
            STORE: begin
                storeNow = eventMode ? (hitB && (mode == MODE_EVENT_B || st_r.seenA)) :
                    (busValid && opcodeFetch);
            end
            CIRCULAR: begin
                storeNow = busValid && opcodeFetch;
                if (trig) begin
                    st_nxt.run = IDLE;
                    st_nxt.control[CTL_CAPTURE_ACTIVE] = 1'b0;
                    st_nxt.brk = st_r.control[CTL_BREAK_ENABLE];
                end
            end
            default: st_nxt.run = IDLE;
        endcase
        if (storeNow) begin
            st_nxt.fifo[st_r.wrPtr] = storeWord;
            st_nxt.wrPtr = st_r.wrPtr + 3'h1;
            if (st_r.count != FIFO_FULL_COUNT) begin
                st_nxt.count = st_r.count + 4'h1;
            end
            if (st_r.run != CIRCULAR && st_r.count == FIFO_FULL_COUNT - 4'h1) begin
                st_nxt.run = IDLE;
                st_nxt.control[CTL_CAPTURE_ACTIVE] = 1'b0;
                st_nxt.brk = st_r.control[CTL_BREAK_ENABLE];
            end
        end
        if (st_nxt.run == IDLE && armed) begin
            st_nxt.rdPtr = st_nxt.wrPtr - st_nxt.count[2:0];
        end
        // a trace control write overrides the run state and control byte set by an automatic run end of the same cycle
        if (wrEn && wrStrb[0]) begin
            case (wrAddr)
                OFS_TRACE_CONTROL: begin
                    st_nxt.control = wrData[7:0];
                    if (secure && !st_r.control[CTL_MODULE_ENABLE]) begin
                        st_nxt.control[CTL_MODULE_ENABLE] = 1'b0;
                    end
                    if (!st_nxt.control[CTL_MODULE_ENABLE] ||
                        !st_nxt.control[CTL_CAPTURE_ACTIVE]) begin
                        st_nxt.run = IDLE;
                        st_nxt.control[CTL_CAPTURE_ACTIVE] = 1'b0;
                    end else begin
                        st_nxt.run = beginTrace ? WAIT_TRIG : CIRCULAR;
                        st_nxt.flagA = 1'b0;
                        st_nxt.flagB = 1'b0;
                        st_nxt.seenA = 1'b0;
                        st_nxt.count = 4'h0;
                        st_nxt.wrPtr = 3'h0;
                        st_nxt.rdPtr = 3'h0;
                    end
                end
                OFS_TRIGGER_CONFIG: begin
                    if (!st_r.control[CTL_CAPTURE_ACTIVE]) begin
                        st_nxt.trigCfg = wrData[7:0] & CFG_WRITE_MASK;
                    end
                end
                OFS_COMP_A: st_nxt.compA[7:0] = wrData[7:0];
                OFS_COMP_B: st_nxt.compB[7:0] = wrData[7:0];
                default: st_nxt.trigCfg = st_nxt.trigCfg;
            endcase
        end
        if (wrEn && wrStrb[1]) begin
            if (wrAddr == OFS_COMP_A) st_nxt.compA[15:8] = wrData[15:8];
            if (wrAddr == OFS_COMP_B) st_nxt.compB[15:8] = wrData[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.control <= RST_TRACE_CONTROL;
            st_r.trigCfg <= RST_TRIGGER_CONFIG;
            st_r.compA <= RST_COMP;
            st_r.compB <= RST_COMP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign breakReq = st_r.brk;
    assign breakTag = st_r.control[CTL_BREAK_TAG];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    cfg_zero_bits_a: assert property (st_r.trigCfg[5:4] == 2'b00)
        else $error("config bits 5:4 not zero");
    cfg_write_lock_a: assert property (st_r.control[CTL_CAPTURE_ACTIVE] && wrEn &&
        wrAddr == OFS_TRIGGER_CONFIG |=> $stable(st_r.trigCfg))
        else $error("config changed while armed");
    no_trig_high_a: assert property (mode > MODE_OUTSIDE |-> !trig)
        else $error("reserved mode triggered");
    flag_a_set_a: assert property (armed && hitA |=> st_r.flagA)
        else $error("A flag not set on match");
    flag_b_set_a: assert property (armed && hitB |=> st_r.flagB)
        else $error("B flag not set on match");
    arm_mirror_a: assert property (st_r.control[CTL_MODULE_ENABLE] |->
        statusByte[STS_CAPTURE_ACTIVE] == st_r.control[CTL_CAPTURE_ACTIVE])
        else $error("armed flag differs from control");
    end_trig_a: assert property (st_r.run == CIRCULAR && trig && !wrEn |=>
        st_r.run == IDLE && st_r.brk == $past(st_r.control[CTL_BREAK_ENABLE]))
        else $error("end trace did not stop on trigger");
    stop_write_a: assert property (wrEn && wrStrb[0] && wrAddr == OFS_TRACE_CONTROL &&
        !wrData[CTL_CAPTURE_ACTIVE] |=> st_r.run == IDLE)
        else $error("run not stopped by write");
    count_max_a: assert property (st_r.count <= FIFO_FULL_COUNT)
        else $error("valid count above eight");
    count_hold_a: assert property (!armed && !wrEn |=> $stable(st_r.count))
        else $error("valid count changed while idle");
    secure_en_a: assert property (secure && !st_r.control[CTL_MODULE_ENABLE] |=>
        !st_r.control[CTL_MODULE_ENABLE])
        else $error("enable set while secure");

endmodule : bus_trace_trigger

/* dv/cpu_bus_model.sv */
// cpu bus stand-in: one bus cycle per call, with an optional execute pulse
// assumes clk is the bench clock; after each call address and data show inverted values, never stale ones
`timescale 1ns/100ps
module cpu_bus_model (
    input wire logic clk, // bus clock
    output logic busValid, // bus cycle strobe
    output logic [15:0] busAddr, // bus address
    output logic [7:0] busData, // bus data
    output logic opcodeFetch, // fetch qualifier
    output logic opcodeExec // execute pulse
);
    initial begin
        {busValid, opcodeFetch, opcodeExec} = 3'h0;
        busAddr = 16'h0000;
        busData = 8'h00;
    end
    // data byte mirrors the address low byte so data compares are predictable
    task automatic cyc(input logic [15:0] a, input logic v, input logic e);
        @(posedge clk);
        busValid <= v;
        busAddr <= a;
        busData <= a[7:0];
        opcodeFetch <= v;
        opcodeExec <= e;
        @(posedge clk);
        {busValid, opcodeFetch, opcodeExec} <= 3'h0;
        busAddr <= ~a;
        busData <= ~a[7:0];
    endtask : cyc
endmodule : cpu_bus_model

/* dv/bus_trace_trigger_tb.sv */
// self-checking bench for the trace trigger block
// assumes the trace_trig_pkg map and an AXI4-Lite slave that answers in a few cycles
`timescale 1ns/100ps
module bus_trace_trigger_tb;
    import trace_trig_pkg::*;
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, secure, brk;
    logic awready, wready, bvalid, arready, rvalid, busValid, opcodeFetch, opcodeExec;
    logic breakReq, breakTag;
    logic [7:0] awaddr, araddr, busData;
    logic [15:0] busAddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int fails, samples_checked;
    bus_trace_trigger dut_u (.*);
    cpu_bus_model cpu_u (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk) if (breakReq === 1'b1) brk <= 1'b1;
    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    // ready is sampled on the falling edge so the decision never races the flops
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        logic ar, rv;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge clk);
            ar = arvalid & arready;
            rv = rvalid;
            v = rdata;
            s = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reset_and_map();
        wr(OFS_RUN_STATUS, 32'hFF);
        rd(OFS_RUN_STATUS, d, r);
        chk(d, 32'h0);
        rd(8'h1C, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFS_TRIGGER_CONFIG, 32'hFF);
        rd(OFS_TRIGGER_CONFIG, d, r);
        chk(d, {24'h0, CFG_WRITE_MASK});
        secure <= 1'b1;
        wr(OFS_TRACE_CONTROL, 32'hC0);
        rd(OFS_TRACE_CONTROL, d, r);
        chk(d, 32'h0);
        secure <= 1'b0;
    endtask : reset_and_map
    // arm with break enabled, one fetch, then disarm for the next case
    task automatic trig(input logic [7:0] c, input logic [15:0] a, input logic [7:0] m, e);
        wr(OFS_TRIGGER_CONFIG, {24'h0, c});
        wr(OFS_TRACE_CONTROL, 32'hD0);
        cpu_u.cyc(a, 1'b1, 1'b0);
        rd(OFS_RUN_STATUS, d, r);
        chk(d & {24'h0, m}, {24'h0, e});
        wr(OFS_TRACE_CONTROL, 32'h00);
    endtask : trig
    task automatic mode_table();
        wr(OFS_COMP_A, 32'h1234);
        wr(OFS_COMP_B, 32'h5678);
        trig(8'h00, 16'h1234, 8'hF0, 8'h80);
        chk({31'h0, brk}, 32'h1);
        trig(8'h01, 16'h5678, 8'hF0, 8'h40);
        trig(8'h02, 16'h5678, 8'h20, 8'h20);
        trig(8'h04, 16'h1234, 8'hA0, 8'hA0);
        trig(8'h05, 16'h1234, 8'h20, 8'h20);
        trig(8'h06, 16'h1234, 8'h20, 8'h00);
        trig(8'h07, 16'h2000, 8'h20, 8'h00);
        trig(8'h08, 16'h2000, 8'h20, 8'h20);
        trig(8'h08, 16'h0100, 8'h20, 8'h00);
        trig(8'h09, 16'h1234, 8'h20, 8'h20);
        trig(8'h0F, 16'h1234, 8'h20, 8'h20);
    endtask : mode_table
    task automatic armed_lock_and_tag();
        wr(OFS_TRIGGER_CONFIG, 32'h80);
        wr(OFS_TRACE_CONTROL, 32'hE0);
        wr(OFS_TRIGGER_CONFIG, 32'h09);
        rd(OFS_TRIGGER_CONFIG, d, r);
        chk(d, 32'h80);
        chk({31'h0, breakTag}, 32'h1);
        cpu_u.cyc(16'h1234, 1'b1, 1'b0);
        rd(OFS_RUN_STATUS, d, r);
        chk(d & 32'h20, 32'h20);
        cpu_u.cyc(16'h0300, 1'b0, 1'b1);
        rd(OFS_RUN_STATUS, d, r);
        chk(d & 32'hF0, 32'h80);
        wr(OFS_TRIGGER_CONFIG, 32'h09);
        wr(OFS_TRACE_CONTROL, 32'hC0);
        wr(OFS_TRACE_CONTROL, 32'h80);
        rd(OFS_RUN_STATUS, d, r);
        chk(d & 32'h20, 32'h0);
    endtask : armed_lock_and_tag
    // ten hits on one address overfill the store; the count stops at full and survives reads
    task automatic begin_run(input logic [7:0] c, input logic [15:0] a, input logic [7:0] m, e);
        wr(OFS_TRIGGER_CONFIG, {24'h0, c});
        wr(OFS_TRACE_CONTROL, 32'hC0);
        repeat (10) cpu_u.cyc(a, 1'b1, 1'b0);
        rd(OFS_RUN_STATUS, d, r);
        chk(d & {24'h0, m}, {24'h0, e});
        rd(OFS_FIFO_LOW_BYTE, d, r);
        chk(d, {24'h0, a[7:0]});
        rd(OFS_RUN_STATUS, d, r);
        chk(d & {24'h0, m}, {24'h0, e});
    endtask : begin_run
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, secure, brk} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reset_and_map();
        mode_table();
        armed_lock_and_tag();
        begin_run(8'h40, 16'h1234, 8'hFF, {4'h8, FIFO_FULL_COUNT});
        begin_run(8'h03, 16'h5678, 8'h2F, {4'h0, FIFO_FULL_COUNT});
        rd(OFS_FIFO_HIGH_BYTE, d, r);
        chk(d, 32'h0);
        summarize();
    end
    initial begin
        #200us;
        fails++;
        summarize();
    end
endmodule : bus_trace_trigger_tb
